// File: bench/debug_host_model.sv
// Debug host model: drives the mode pin and the reset pin
`default_nettype none
module debug_host_model (
    // Clock
    input  wire logic pclk,
    // Bench requests
    input  wire logic want_debug,
    input  wire logic want_reset,
    // Device pins
    output logic      mode_select_debug_pin = 1'b1,
    output logic      reset_pin_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulled high unless the host asks for debug across reset exit
    always @(posedge pclk) begin
        mode_select_debug_pin <= ~want_debug;
        reset_pin_n           <= ~want_reset;
    end
endmodule
`default_nettype wire

// File: bench/tb_operating_mode_controller.sv
// Self-checking bench for the operating-mode controller
`default_nettype none
module tb_operating_mode_controller;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, serr, mode_select_debug_pin, reset_pin_n;
    logic want_dbg = 1'b0, want_rst = 1'b0, cpu_clock_on, bus_clock_on, cpu_fetch_vector;
    logic stacking_start, clear_irq_mask, illegal_opcode_reset, por_restart, regulator_full;
    logic debug_clocks_on, ref_clocks_on, circuits_powered, ram_retained;
    logic [15:0] vector_addr;
    logic [6:0] c;
    logic [6:0] corner [6] = '{7'h00, 7'h03, 7'h0d, 7'h01, 7'h31, 7'h11};
    opmode_pkg::stop_kind_t k;
    int err_total = 0, n_tests = 0, n_clr = 0, n_stk = 0, n_ill = 0, n_por = 0, n_fv = 0, n0, n1;
    int seed = 32'hd9354e90;
    always #25 pclk = ~pclk;
    operating_mode_controller operating_mode_controller_inst (.*);
    debug_host_model debug_host_model_inst (.pclk(pclk), .want_debug(want_dbg),
        .want_reset(want_rst), .mode_select_debug_pin(mode_select_debug_pin),
        .reset_pin_n(reset_pin_n));
    always @(posedge pclk) begin
        if (clear_irq_mask === 1'b1) n_clr++;
        if (stacking_start === 1'b1) n_stk++;
        if (illegal_opcode_reset === 1'b1) n_ill++;
        if (por_restart === 1'b1) n_por++;
        if (cpu_fetch_vector === 1'b1) n_fv++;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        q = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task st(input logic [2:0] m);
        apb(1'b0, opmode_pkg::STATUS_OFS, 32'h0);
        chk(q[2:0], m);
    endtask
    task ev(input int b);
        apb(1'b1, opmode_pkg::EVENT_OFS, 32'h1 << b);
    endtask
    task cmd(input logic [2:0] x, input logic [1:0] r);
        apb(1'b1, opmode_pkg::CMD_OFS, {29'h0, x});
        apb(1'b0, opmode_pkg::RESP_OFS, 32'h0);
        chk(q[1:0], r);
    endtask
    task rst(input logic dbg);
        presetn <= 1'b0; want_dbg <= dbg;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    function automatic opmode_pkg::stop_kind_t kind(input logic [6:0] v);
        if (!v[0]) return opmode_pkg::STOP_NONE;
        if (v[1] || (v[2] && v[3]) || !v[4]) return opmode_pkg::STOP_3;
        return v[5] ? opmode_pkg::STOP_2 : opmode_pkg::STOP_1;
    endfunction
    task final_report;
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        rst(1'b0);
        st(opmode_pkg::ST_RUN);
        chk(vector_addr, 16'hfffe);
        apb(1'b0, 8'h20, 32'h0);
        chk(serr, 1'b1);
        cmd(opmode_pkg::CMD_MEM, opmode_pkg::RESP_DONE);
        cmd(opmode_pkg::CMD_CPU_REG, opmode_pkg::RESP_REFUSED);
        ev(opmode_pkg::EV_WAIT);
        st(opmode_pkg::ST_WAIT);
        chk(cpu_clock_on, 1'b0);
        chk({bus_clock_on, regulator_full}, 2'b11);
        chk(n_clr, 1);
        cmd(opmode_pkg::CMD_MEM_STATUS, opmode_pkg::RESP_STOPWAIT);
        cmd(opmode_pkg::CMD_DBG_REG, opmode_pkg::RESP_REFUSED);
        ev(opmode_pkg::EV_IRQ);
        st(opmode_pkg::ST_RUN);
        chk(n_stk, 1);
        ev(opmode_pkg::EV_WAIT);
        cmd(opmode_pkg::CMD_HALT, opmode_pkg::RESP_DONE);
        st(opmode_pkg::ST_DEBUG);
        chk(cpu_clock_on, 1'b0);
        cmd(opmode_pkg::CMD_CPU_REG, opmode_pkg::RESP_DONE);
        cmd(opmode_pkg::CMD_RESUME, opmode_pkg::RESP_DONE);
        for (int b = 2; b < 5; b++) begin
            ev(b);
            st(opmode_pkg::ST_DEBUG);
            cmd(b == 3 ? opmode_pkg::CMD_TRACE : opmode_pkg::CMD_RESUME, 2'h1);
        end
        want_dbg <= 1'b1;
        n0 = n_fv;
        ev(opmode_pkg::EV_FORCE_RST);
        st(opmode_pkg::ST_DEBUG);
        chk(n_fv - n0, 1);
        rst(1'b1);
        st(opmode_pkg::ST_DEBUG);
        // Fresh reset per stop case: wake paths differ and leave odd state
        for (int i = 0; i < 24; i++) begin
            c = (i < 6) ? corner[i] : 7'($random(seed));
            k = kind(c);
            rst(1'b0);
            apb(1'b1, opmode_pkg::CTRL_OFS, {25'h0, c});
            n0 = n_ill;
            n1 = n_por;
            ev(opmode_pkg::EV_STOP);
            apb(1'b0, opmode_pkg::STATUS_OFS, 32'h0);
            chk(q[4:3], k);
            if (k == opmode_pkg::STOP_NONE) chk(n_ill - n0, 1);
            else begin
                chk({cpu_clock_on, bus_clock_on}, 2'b00);
                chk(circuits_powered, k == opmode_pkg::STOP_3);
                chk(ram_retained, k != opmode_pkg::STOP_1);
                if (c[1]) chk(debug_clocks_on, 1'b1);
                else if (c[2] && c[3]) chk(regulator_full, 1'b1);
                if (k == opmode_pkg::STOP_3) chk(ref_clocks_on, c[6]);
                if (i[0]) ev(k == opmode_pkg::STOP_3 ? opmode_pkg::EV_IRQ
                                                      : opmode_pkg::EV_WAKE_PIN);
                else begin
                    want_rst <= 1'b1;
                    repeat (3) @(posedge pclk);
                    want_rst <= 1'b0;
                    repeat (3) @(posedge pclk);
                end
                st(opmode_pkg::ST_RUN);
                chk(n_por - n1, k != opmode_pkg::STOP_3);
                apb(1'b0, opmode_pkg::CTRL_OFS, 32'h0);
                chk(q[6:0], k == opmode_pkg::STOP_3 ? c : 7'h00);
            end
        end
        final_report;
    end
    initial begin
        #2000000;
        err_total++;
        final_report;
    end
endmodule
`default_nettype wire

// File: inc/opmode_pkg.sv
// Package: constants, register map and mode encodings for the operating-mode controller
`default_nettype none
package opmode_pkg;
    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS    = 8'h08;
    localparam logic [7:0] RESP_OFS   = 8'h0c;
    localparam logic [7:0] EVENT_OFS  = 8'h10;
    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_STOP_PERMIT   = 0;
    localparam int CTRL_DEBUG_PERMIT  = 1;
    localparam int CTRL_LVD_ON        = 2;
    localparam int CTRL_LVD_IN_STOP   = 3;
    localparam int CTRL_POWERDOWN     = 4;
    localparam int CTRL_PARTIAL_PD    = 5;
    localparam int CTRL_REFCLK_STOP   = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // ****************************************************************
    // Event register fields (write 1 to request)
    // ****************************************************************
    localparam int EV_WAIT       = 0;
    localparam int EV_STOP       = 1;
    localparam int EV_HALT_INSN  = 2;
    localparam int EV_SERIAL_BRK = 3;
    localparam int EV_CHIP_BRK   = 4;
    localparam int EV_IRQ        = 5;
    localparam int EV_WAKE_PIN   = 6;
    localparam int EV_FORCE_RST  = 7;
    // ****************************************************************
    // Reset vector location and response codes
    // ****************************************************************
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
    localparam logic [1:0]  RESP_NONE     = 2'h0;
    localparam logic [1:0]  RESP_DONE     = 2'h1;
    localparam logic [1:0]  RESP_REFUSED  = 2'h2;
    localparam logic [1:0]  RESP_STOPWAIT = 2'h3;
    // ****************************************************************
    // Debug commands and stop flavours
    // ****************************************************************
    typedef enum logic [2:0] {
        CMD_MEM        = 3'h0,
        CMD_MEM_STATUS = 3'h1,
        CMD_DBG_REG    = 3'h2,
        CMD_HALT       = 3'h3,
        CMD_CPU_REG    = 3'h4,
        CMD_TRACE      = 3'h5,
        CMD_RESUME     = 3'h6,
        CMD_SPARE      = 3'h7
    } dbg_cmd_t;
    typedef enum logic [1:0] {
        STOP_NONE = 2'h0,
        STOP_3    = 2'h1,
        STOP_2    = 2'h2,
        STOP_1    = 2'h3
    } stop_kind_t;
    // Gray codes along reset -> run -> wait -> stop -> debug
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN   = 3'b001,
        ST_WAIT  = 3'b011,
        ST_STOP  = 3'b010,
        ST_DEBUG = 3'b110
    } mode_t;
endpackage
`default_nettype wire

// File: rtl/operating_mode_controller.sv
// Operating-mode controller: run, debug, wait and stop sequencing behind APB
//
// Overview of operation
// RULE_01 - Mode pin high at reset exit: run
// RULE_02 - Run start fetches reset vector at 0xFFFE
// RULE_03 - Five events enter debug mode
// RULE_04 - CPU suspended while in debug mode
// RULE_05 - Non-intrusive commands accepted in run, debug
// RULE_06 - CPU-register, trace, resume only in debug
// RULE_07 - Wait instruction gates the CPU clock
// RULE_08 - Wait keeps system clocks and regulation
// RULE_09 - Wait entry clears interrupt mask flag
// RULE_10 - Interrupt ends wait, starts stacking
// RULE_11 - Wait accepts only halt and status-access
// RULE_12 - Status access in wait returns stop/wait error
// RULE_13 - Halt command in wait enters debug
// RULE_14 - Permitted stop halts bus, CPU clocks
// RULE_15 - Stop without permit: illegal-opcode reset
// RULE_16 - Debug permit selects stop3, debug clocks on
// RULE_17 - Both low-voltage bits select stop3, regulator on
// RULE_18 - Powerdown bits pick stop3, stop2, stop1
// RULE_19 - Stop mode entered after instruction completes
// RULE_20 - Stop1 full off, stop2 partial, stop3 on
// RULE_21 - Reference clocks may run during stop
// RULE_22 - Stop3 left by reset pin or interrupt
// RULE_23 - Stop2/stop1 wake restarts as power-on
`default_nettype none
module operating_mode_controller (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and core
    input  wire logic        mode_select_debug_pin,
    input  wire logic        reset_pin_n,
    // Core controls
    output logic             cpu_clock_on,
    output logic             bus_clock_on,
    output logic             cpu_fetch_vector,
    output logic [15:0]      vector_addr,
    output logic             stacking_start,
    output logic             clear_irq_mask,
    output logic             illegal_opcode_reset,
    output logic             por_restart,
    // Power controls
    output logic             regulator_full,
    output logic             debug_clocks_on,
    output logic             ref_clocks_on,
    output logic             circuits_powered,
    output logic             ram_retained
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        opmode_pkg::mode_t      mode;
        opmode_pkg::stop_kind_t stop_kind;
        logic [6:0]             ctrl;
        logic [1:0]             resp;
        logic                   por_pending;
        logic [31:0]            prdata;
        logic [15:0]            vector_addr;
        logic                   pready;
        logic                   pslverr;
        logic                   cpu_clock_on;
        logic                   bus_clock_on;
        logic                   cpu_fetch_vector;
        logic                   stacking_start;
        logic                   clear_irq_mask;
        logic                   illegal_opcode_reset;
        logic                   por_restart;
        logic                   regulator_full;
        logic                   debug_clocks_on;
        logic                   ref_clocks_on;
        logic                   circuits_powered;
        logic                   ram_retained;
    } state_t;

    state_t st;
    state_t next_st;

    logic                 acc;
    logic                 wr;
    logic [7:0]           ev;
    logic                 cmd_wr;
    opmode_pkg::dbg_cmd_t cmd;
    logic                 halt_cmd;

    assign acc      = psel && penable && !st.pready;
    // Effects land on the completing edge; read data is prepared one edge earlier
    assign wr       = psel && penable && st.pready && pwrite;
    assign ev       = (wr && paddr == opmode_pkg::EVENT_OFS) ? pwdata[7:0] : 8'h00;
    assign cmd_wr   = wr && paddr == opmode_pkg::CMD_OFS;
    assign cmd      = opmode_pkg::dbg_cmd_t'(pwdata[2:0]);
    assign halt_cmd = cmd_wr && cmd == opmode_pkg::CMD_HALT;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.pready = acc;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        next_st.cpu_fetch_vector = 1'b0;
        next_st.stacking_start = 1'b0;
        next_st.clear_irq_mask = 1'b0;
        next_st.illegal_opcode_reset = 1'b0;
        next_st.por_restart = 1'b0;

        // Register reads and control writes
        if (acc) begin
            unique case (paddr)
                opmode_pkg::CTRL_OFS: begin
                    next_st.prdata = {25'h0, st.ctrl};
                end
                opmode_pkg::STATUS_OFS: begin
                    next_st.prdata = {27'h0, st.stop_kind, st.mode};
                end
                opmode_pkg::RESP_OFS: begin
                    next_st.prdata = {30'h0, st.resp};
                end
                opmode_pkg::CMD_OFS, opmode_pkg::EVENT_OFS: begin
                    next_st.prdata = 32'h0000_0000;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        if (wr && paddr == opmode_pkg::CTRL_OFS) begin
            next_st.ctrl = pwdata[6:0];
        end

        // Debug command admission
        if (cmd_wr) begin
            unique case (st.mode)
                opmode_pkg::ST_RUN: begin
                    next_st.resp = (cmd <= opmode_pkg::CMD_HALT) ? opmode_pkg::RESP_DONE
                                                                : opmode_pkg::RESP_REFUSED; // RULE_05 RULE_06
                end
                opmode_pkg::ST_DEBUG: begin
                    next_st.resp = (cmd == opmode_pkg::CMD_SPARE) ? opmode_pkg::RESP_REFUSED
                                                                 : opmode_pkg::RESP_DONE; // RULE_05 RULE_06
                end
                opmode_pkg::ST_WAIT, opmode_pkg::ST_STOP: begin
                    if (cmd == opmode_pkg::CMD_MEM_STATUS) begin
                        next_st.resp = opmode_pkg::RESP_STOPWAIT; // RULE_12
                    end else if (cmd == opmode_pkg::CMD_HALT) begin
                        next_st.resp = opmode_pkg::RESP_DONE;
                    end else begin
                        next_st.resp = opmode_pkg::RESP_REFUSED; // RULE_11
                    end
                end
                default: begin
                    next_st.resp = opmode_pkg::RESP_REFUSED;
                end
            endcase
        end

        // Mode sequencing
        unique case (st.mode)
            opmode_pkg::ST_RESET: begin
                // Pin level caught after presetn release, even while reset_pin_n is still low
                next_st.cpu_fetch_vector = 1'b1; // RULE_02 RULE_23
                next_st.vector_addr = opmode_pkg::RESET_VECTOR_ADDR; // RULE_02
                next_st.cpu_clock_on = 1'b1;
                next_st.bus_clock_on = 1'b1;
                next_st.circuits_powered = 1'b1;
                next_st.ram_retained = 1'b1;
                next_st.regulator_full = 1'b1;
                next_st.debug_clocks_on = 1'b1;
                next_st.ref_clocks_on = 1'b1;
                next_st.por_restart = st.por_pending;
                next_st.por_pending = 1'b0;
                if (mode_select_debug_pin) begin
                    next_st.mode = opmode_pkg::ST_RUN; // RULE_01
                end else begin
                    next_st.mode = opmode_pkg::ST_DEBUG; // RULE_03
                    next_st.cpu_clock_on = 1'b0;
                end
            end
            opmode_pkg::ST_RUN: begin
                if (halt_cmd || ev[opmode_pkg::EV_HALT_INSN] ||
                    ev[opmode_pkg::EV_SERIAL_BRK] || ev[opmode_pkg::EV_CHIP_BRK]) begin
                    next_st.mode = opmode_pkg::ST_DEBUG; // RULE_03
                    next_st.cpu_clock_on = 1'b0; // RULE_04
                end else if (ev[opmode_pkg::EV_WAIT]) begin
                    next_st.mode = opmode_pkg::ST_WAIT;
                    next_st.cpu_clock_on = 1'b0; // RULE_07
                    next_st.clear_irq_mask = 1'b1; // RULE_09
                end else if (ev[opmode_pkg::EV_STOP]) begin
                    // Applied on the edge that retires the instruction
                    if (!st.ctrl[opmode_pkg::CTRL_STOP_PERMIT]) begin
                        next_st.illegal_opcode_reset = 1'b1; // RULE_15
                        next_st.mode = opmode_pkg::ST_RESET;
                    end else begin
                        next_st.mode = opmode_pkg::ST_STOP; // RULE_19
                        next_st.cpu_clock_on = 1'b0; // RULE_14
                        next_st.bus_clock_on = 1'b0; // RULE_14
                        next_st.ref_clocks_on = st.ctrl[opmode_pkg::CTRL_REFCLK_STOP]; // RULE_21
                        if (st.ctrl[opmode_pkg::CTRL_DEBUG_PERMIT]) begin
                            next_st.stop_kind = opmode_pkg::STOP_3; // RULE_16
                            next_st.debug_clocks_on = 1'b1;
                            next_st.regulator_full = 1'b1;
                        end else if (st.ctrl[opmode_pkg::CTRL_LVD_ON] &&
                                     st.ctrl[opmode_pkg::CTRL_LVD_IN_STOP]) begin
                            next_st.stop_kind = opmode_pkg::STOP_3; // RULE_17
                            next_st.debug_clocks_on = 1'b0;
                            next_st.regulator_full = 1'b1;
                        end else begin
                            next_st.debug_clocks_on = 1'b0;
                            next_st.regulator_full = 1'b0;
                            if (!st.ctrl[opmode_pkg::CTRL_POWERDOWN]) begin
                                next_st.stop_kind = opmode_pkg::STOP_3; // RULE_18
                            end else if (st.ctrl[opmode_pkg::CTRL_PARTIAL_PD]) begin
                                next_st.stop_kind = opmode_pkg::STOP_2; // RULE_18
                                next_st.circuits_powered = 1'b0; // RULE_20
                            end else begin
                                next_st.stop_kind = opmode_pkg::STOP_1; // RULE_18
                                next_st.circuits_powered = 1'b0; // RULE_20
                                next_st.ram_retained = 1'b0; // RULE_20
                            end
                        end
                    end
                end
            end
            opmode_pkg::ST_WAIT: begin
                // System clocks and regulator stay as in run
                next_st.bus_clock_on = 1'b1; // RULE_08
                next_st.regulator_full = 1'b1; // RULE_08
                if (halt_cmd) begin
                    next_st.mode = opmode_pkg::ST_DEBUG; // RULE_13
                end else if (ev[opmode_pkg::EV_IRQ]) begin
                    next_st.mode = opmode_pkg::ST_RUN; // RULE_10
                    next_st.cpu_clock_on = 1'b1;
                    next_st.stacking_start = 1'b1; // RULE_10
                end
            end
            opmode_pkg::ST_STOP: begin
                if (st.stop_kind == opmode_pkg::STOP_3) begin
                    if (!reset_pin_n) begin
                        next_st.mode = opmode_pkg::ST_RESET; // RULE_22
                        next_st.stop_kind = opmode_pkg::STOP_NONE;
                    end else if (halt_cmd && st.debug_clocks_on) begin
                        next_st.mode = opmode_pkg::ST_DEBUG;
                        next_st.stop_kind = opmode_pkg::STOP_NONE;
                        next_st.bus_clock_on = 1'b1;
                        next_st.ref_clocks_on = 1'b1;
                    end else if (ev[opmode_pkg::EV_IRQ]) begin
                        next_st.mode = opmode_pkg::ST_RUN; // RULE_22
                        next_st.stop_kind = opmode_pkg::STOP_NONE;
                        next_st.cpu_clock_on = 1'b1;
                        next_st.bus_clock_on = 1'b1;
                        next_st.ref_clocks_on = 1'b1;
                        next_st.debug_clocks_on = 1'b1;
                        next_st.regulator_full = 1'b1;
                        next_st.stacking_start = 1'b1;
                    end
                end else if (ev[opmode_pkg::EV_WAKE_PIN] || !reset_pin_n) begin
                    // Deep stops lose register state: restart as power-on
                    next_st.mode = opmode_pkg::ST_RESET; // RULE_23
                    next_st.stop_kind = opmode_pkg::STOP_NONE;
                    next_st.ctrl = opmode_pkg::CTRL_RESET; // RULE_23
                    next_st.por_pending = 1'b1;
                end
            end
            opmode_pkg::ST_DEBUG: begin
                next_st.cpu_clock_on = 1'b0; // RULE_04
                if (cmd_wr && (cmd == opmode_pkg::CMD_RESUME || cmd == opmode_pkg::CMD_TRACE)) begin
                    next_st.mode = opmode_pkg::ST_RUN; // RULE_06
                    next_st.cpu_clock_on = 1'b1;
                end
            end
            default: begin
                next_st.mode = opmode_pkg::ST_RESET;
            end
        endcase

        // Debug force reset restarts the mode-pin sampling
        if (ev[opmode_pkg::EV_FORCE_RST]) begin
            next_st.mode = opmode_pkg::ST_RESET; // RULE_03
            next_st.stop_kind = opmode_pkg::STOP_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata               = st.prdata;
    assign pready               = st.pready;
    assign pslverr              = st.pslverr;
    assign cpu_clock_on         = st.cpu_clock_on;
    assign bus_clock_on         = st.bus_clock_on;
    assign cpu_fetch_vector     = st.cpu_fetch_vector;
    assign vector_addr          = st.vector_addr;
    assign stacking_start       = st.stacking_start;
    assign clear_irq_mask       = st.clear_irq_mask;
    assign illegal_opcode_reset = st.illegal_opcode_reset;
    assign por_restart          = st.por_restart;
    assign regulator_full       = st.regulator_full;
    assign debug_clocks_on      = st.debug_clocks_on;
    assign ref_clocks_on        = st.ref_clocks_on;
    assign circuits_powered     = st.circuits_powered;
    assign ram_retained         = st.ram_retained;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_run_from_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        st.mode == opmode_pkg::ST_RESET && mode_select_debug_pin |=> st.mode == opmode_pkg::ST_RUN)
        else $error("pin high did not give run");
    a_vector_fetch: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        st.mode == opmode_pkg::ST_RESET |=> cpu_fetch_vector && vector_addr == 16'hfffe)
        else $error("no vector fetch after reset");
    a_halt_insn: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        st.mode == opmode_pkg::ST_RUN && ev[opmode_pkg::EV_HALT_INSN] && !ev[7]
        |=> st.mode == opmode_pkg::ST_DEBUG)
        else $error("halt instruction ignored");
    a_debug_suspend: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        st.mode == opmode_pkg::ST_DEBUG && $past(st.mode) == opmode_pkg::ST_DEBUG |-> !cpu_clock_on)
        else $error("cpu clocked in debug");
    a_run_refuse: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        st.mode == opmode_pkg::ST_RUN && cmd_wr && cmd == opmode_pkg::CMD_CPU_REG
        |=> st.resp == opmode_pkg::RESP_REFUSED)
        else $error("active command taken in run");
    a_wait_entry: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        $rose(st.mode == opmode_pkg::ST_WAIT) |-> clear_irq_mask && !cpu_clock_on && bus_clock_on)
        else $error("wait entry wrong");
    a_wait_status: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
        st.mode == opmode_pkg::ST_WAIT && cmd_wr && cmd == opmode_pkg::CMD_MEM_STATUS
        |=> st.resp == opmode_pkg::RESP_STOPWAIT)
        else $error("no stop/wait error");
    a_no_permit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
        st.mode == opmode_pkg::ST_RUN && ev == 8'h02 && !st.ctrl[0] |=> illegal_opcode_reset)
        else $error("stop without permit not reset");
    a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        st.mode == opmode_pkg::ST_STOP |-> !bus_clock_on && !cpu_clock_on)
        else $error("clocks running in stop");
    a_stop1_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        st.stop_kind == opmode_pkg::STOP_1 |-> !circuits_powered && !ram_retained)
        else $error("stop1 not powered down");
    a_wait_halt: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        st.mode == opmode_pkg::ST_WAIT && halt_cmd |=> st.mode == opmode_pkg::ST_DEBUG)
        else $error("halt ignored in wait");
    a_stop_dbg: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
        st.mode == opmode_pkg::ST_RUN && ev == 8'h02 && st.ctrl[1:0] == 2'b11
        |=> st.stop_kind == opmode_pkg::STOP_3 && debug_clocks_on)
        else $error("debug permit stop wrong");
    a_wait_clocks: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        st.mode == opmode_pkg::ST_WAIT |-> bus_clock_on && regulator_full)
        else $error("wait lost clocks");

    c_wait_irq:  cover property (@(posedge pclk) disable iff (!presetn) stacking_start);
    c_stop2:     cover property (@(posedge pclk) disable iff (!presetn)
        st.stop_kind == opmode_pkg::STOP_2);
    c_debug:     cover property (@(posedge pclk) disable iff (!presetn)
        st.mode == opmode_pkg::ST_DEBUG);
    c_por_again: cover property (@(posedge pclk) disable iff (!presetn) por_restart);
endmodule
`default_nettype wire
